// ### plcpr_cfg.svh
// Register offsets, reset values and timing counts of the PHY control bank
`ifndef PLCPR_CFG_SVH
`define PLCPR_CFG_SVH

// Register indices; byte address is four times the index
`define PLCPR_IDX_GLOBAL_GAIN 16'hfe24
`define PLCPR_IDX_CTRL        16'hfe2c
`define PLCPR_IDX_FEATURE     16'hfe68
`define PLCPR_IDX_PREAMBLE    16'hfe9b
`define PLCPR_IDX_BODY        16'hfe9c

// Control register field positions
`define PLCPR_CTRL_CONV_SLEEP 4
`define PLCPR_CTRL_PHY_SLEEP  3
`define PLCPR_CTRL_WDOG_EN    2
`define PLCPR_CTRL_WDOG_ERR   1
`define PLCPR_CTRL_PHY_RST    0

// Feature register field positions
`define PLCPR_FEAT_IRATIO     5
`define PLCPR_FEAT_PAD_AC     4
`define PLCPR_FEAT_AES        3
`define PLCPR_FEAT_CD1        2
`define PLCPR_FEAT_CD2        1
`define PLCPR_FEAT_CRC        0

// Reset values
`define PLCPR_RST_CTRL        8'h04
`define PLCPR_RST_FEATURE     8'h1f
`define PLCPR_RST_GAIN        8'hff

// Gain that passes samples untouched
`define PLCPR_GAIN_UNITY      8'hff

// Watchdog sampling period
`define PLCPR_CLK_KHZ         125000
`define PLCPR_WDOG_MS         200
`define PLCPR_WDOG_CYCLES     (`PLCPR_WDOG_MS * `PLCPR_CLK_KHZ)

`endif

// ### plcpr_pkg.sv
// Types shared by the PHY control bank
package plcpr_pkg;

  typedef struct packed {
    logic converter_sleep;
    logic physical_layer_sleep;
    logic wdog_enable;
    logic wdog_error;
    logic phy_reset;
  } plcpr_ctrl_s;

  typedef struct packed {
    logic interference_ratio_mode;
    logic padding_count_after_coding;
    logic aes_enable;
    logic carrier_detect_alg1_enable;
    logic carrier_detect_alg2_enable;
    logic hw_crc_enable;
  } plcpr_feat_s;

  typedef struct packed {
    logic        preamble;
    logic [15:0] data;
  } plcpr_smp_s;

  typedef enum logic {
    BUS_IDLE,
    BUS_READ
  } plcpr_bus_e;

endpackage

// ### plcpr_regs.sv
// PHY power, watchdog, feature and transmit gain registers on AHB-Lite
//
// Function
// - Converter sleep bit set blocks reception.
// - Physical-layer sleep bit stops all transmit and receive activity.
// - Watchdog enable bit resets to one, watchdog active from reset.
// - Enabled watchdog samples every 200 ms; error raises interrupt and flag.
// - Reset cycle is write one then zero; PHY held in reset meanwhile.
// - Feature bit 5 enables interference ratio measurement mode.
// - Feature bit 4 selects padding count after coding when one.
// - Feature bit 3 enables on-the-fly AES encrypt and decrypt.
// - Feature bit 2 enables the first early carrier detection algorithm.
// - Feature bit 1 enables the second early carrier detection algorithm.
// - Feature bit 0 enables hardware CRC generation and checking.
// - Every transmit sample is scaled by the global gain, truncated to 16 bits.
// - Global gain 0xff passes samples, 0x00 zeroes them; resets to 0xff.
// - Preamble samples scaled by preamble gain, 24-bit product truncated.
// - Preamble gain 0xff full amplitude, 0x00 zero; resets to 0xff.
// - Body samples scaled by body gain; 0xff unchanged, 0x00 zero.
// - Preamble gain acts on preamble only, body gain on header and payload.
`timescale 1ns/100ps
`include "plcpr_cfg.svh"

module plcpr_regs
  import plcpr_pkg::*;
#(
  parameter int unsigned WDOG_CYCLES = `PLCPR_WDOG_CYCLES
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // PHY status and control
  input  wire logic        phy_fault,
  output logic             phy_irq,
  output plcpr_ctrl_s      ctrl,
  output plcpr_feat_s      feat,
  output logic             rx_enable,
  output logic             tx_enable,
  // Transmit sample stream
  input  wire logic        tx_valid,
  input  plcpr_smp_s       tx_sample,
  output logic             tx_out_valid,
  output logic [15:0]      tx_out
);

  localparam int WDOG_W = $clog2(WDOG_CYCLES + 1);

  // Scale a signed sample by an unsigned gain, keep the upper 16 bits
  function automatic logic [15:0] scale(input logic [15:0] s, input logic [7:0] g);
    logic signed [24:0] p;
    p = $signed(s) * $signed({1'b0, g});
    if (g == `PLCPR_GAIN_UNITY) begin
      return s;
    end
    return p[23:8];
  endfunction

  logic [7:0]        global_gain;
  logic [7:0]        preamble_gain;
  logic [7:0]        body_gain;
  plcpr_bus_e        bus_state;
  logic              wr_pend;
  logic [15:0]       wr_idx;
  logic [15:0]       rd_idx;
  logic [31:0]       next_rdata;
  logic              acc;
  logic [WDOG_W-1:0] wd_cnt;
  logic              wd_tick;
  logic              wd_run;
  logic              s1_valid;
  logic [15:0]       s1_data;
  logic [7:0]        s1_gain;
  logic              tx_ok;

  assign acc     = hsel && htrans[1] && hready;
  assign tx_ok   = !ctrl.physical_layer_sleep && !ctrl.phy_reset;
  assign wd_run  = ctrl.wdog_enable && tx_ok;
  assign wd_tick = wd_run && (wd_cnt == WDOG_W'(WDOG_CYCLES - 1));

  // Bus handshake: writes have no wait, reads one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state <= BUS_IDLE;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= 1'b0;
      wr_idx    <= 16'h0000;
      rd_idx    <= 16'h0000;
    end else begin
      hresp   <= 1'b0;
      wr_pend <= acc && hwrite;
      case (bus_state)
        BUS_IDLE: begin
          if (acc) begin
            wr_idx <= haddr[17:2];
            rd_idx <= haddr[17:2];
            if (!hwrite) begin
              bus_state <= BUS_READ;
              hreadyout <= 1'b0;
            end
          end
        end
        BUS_READ: begin
          bus_state <= BUS_IDLE;
          hreadyout <= 1'b1;
        end
        default: begin
          bus_state <= BUS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // Read mux; unmapped words read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (rd_idx)
      `PLCPR_IDX_GLOBAL_GAIN: next_rdata[7:0] = global_gain;
      `PLCPR_IDX_CTRL:        next_rdata[4:0] = ctrl;
      `PLCPR_IDX_FEATURE:     next_rdata[5:0] = feat;
      `PLCPR_IDX_PREAMBLE:    next_rdata[7:0] = preamble_gain;
      `PLCPR_IDX_BODY:        next_rdata[7:0] = body_gain;
      default:                next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_state == BUS_READ) begin
      hrdata <= next_rdata;
    end
  end

  // Control register; error flag is not software writable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= plcpr_ctrl_s'(5'(`PLCPR_RST_CTRL));
    end else begin
      if (wr_pend && wr_idx == `PLCPR_IDX_CTRL) begin
        ctrl.converter_sleep      <= hwdata[`PLCPR_CTRL_CONV_SLEEP];
        ctrl.physical_layer_sleep <= hwdata[`PLCPR_CTRL_PHY_SLEEP];
        ctrl.wdog_enable          <= hwdata[`PLCPR_CTRL_WDOG_EN];
        ctrl.phy_reset            <= hwdata[`PLCPR_CTRL_PHY_RST];
      end
      if (wd_tick && phy_fault) begin
        ctrl.wdog_error <= 1'b1;
      end else if (ctrl.phy_reset) begin
        ctrl.wdog_error <= 1'b0;
      end
    end
  end

  // Feature enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      feat <= plcpr_feat_s'(6'(`PLCPR_RST_FEATURE));
    end else if (wr_pend && wr_idx == `PLCPR_IDX_FEATURE) begin
      feat.interference_ratio_mode    <= hwdata[`PLCPR_FEAT_IRATIO];
      feat.padding_count_after_coding <= hwdata[`PLCPR_FEAT_PAD_AC];
      feat.aes_enable                 <= hwdata[`PLCPR_FEAT_AES];
      feat.carrier_detect_alg1_enable <= hwdata[`PLCPR_FEAT_CD1];
      feat.carrier_detect_alg2_enable <= hwdata[`PLCPR_FEAT_CD2];
      feat.hw_crc_enable              <= hwdata[`PLCPR_FEAT_CRC];
    end
  end

  // Gain registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      global_gain   <= `PLCPR_RST_GAIN;
      preamble_gain <= `PLCPR_RST_GAIN;
      body_gain     <= `PLCPR_RST_GAIN;
    end else if (wr_pend) begin
      if (wr_idx == `PLCPR_IDX_GLOBAL_GAIN) begin
        global_gain <= hwdata[7:0];
      end
      if (wr_idx == `PLCPR_IDX_PREAMBLE) begin
        preamble_gain <= hwdata[7:0];
      end
      if (wr_idx == `PLCPR_IDX_BODY) begin
        body_gain <= hwdata[7:0];
      end
    end
  end

  // Watchdog sampling timer, cleared to zero in physical-layer sleep and PHY reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_cnt  <= '0;
      phy_irq <= 1'b0;
    end else begin
      phy_irq <= wd_tick && phy_fault;
      if (!wd_run || wd_tick) begin
        wd_cnt <= '0;
      end else begin
        wd_cnt <= wd_cnt + WDOG_W'(1);
      end
    end
  end

  // Path enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_enable <= 1'b0;
      tx_enable <= 1'b0;
    end else begin
      rx_enable <= tx_ok && !ctrl.converter_sleep;
      tx_enable <= tx_ok;
    end
  end

  // Stage one: section gain, global gain carried along
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_valid <= 1'b0;
      s1_data  <= 16'h0000;
      s1_gain  <= 8'h00;
    end else begin
      s1_valid <= tx_valid && tx_ok;
      s1_gain  <= global_gain;
      if (tx_sample.preamble) begin
        s1_data <= scale(tx_sample.data, preamble_gain);
      end else begin
        s1_data <= scale(tx_sample.data, body_gain);
      end
    end
  end

  // Stage two: global gain in cascade
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_out_valid <= 1'b0;
      tx_out       <= 16'h0000;
    end else begin
      tx_out_valid <= s1_valid && tx_ok;
      if (s1_valid && tx_ok) begin
        tx_out <= scale(s1_data, s1_gain);
      end else begin
        tx_out <= 16'h0000;
      end
    end
  end

  // Assertions
  a_conv_sleep_rx: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl.converter_sleep |=> !rx_enable)
    else $error("receive enabled while converter asleep");

  a_phy_sleep_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl.physical_layer_sleep |=> !rx_enable && !tx_enable ##1 !tx_out_valid)
    else $error("activity while PHY asleep");

  a_wdog_err_set: assert property (@(posedge hclk) disable iff (!hresetn)
    wd_tick && phy_fault |=> ctrl.wdog_error && phy_irq ##1 !phy_irq)
    else $error("watchdog error not flagged");

  a_wdog_period: assert property (@(posedge hclk) disable iff (!hresetn)
    wd_tick |=> !wd_tick)
    else $error("watchdog ticks back to back");

  a_err_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl.phy_reset ##1 ctrl.phy_reset |-> !ctrl.wdog_error)
    else $error("error flag survives PHY reset");

  a_err_no_write: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl.wdog_error && !(wd_tick && phy_fault) |=> !ctrl.wdog_error)
    else $error("error flag set without fault");

  a_feat_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend && wr_idx == `PLCPR_IDX_FEATURE |=> feat == $past(hwdata[5:0]))
    else $error("feature register not written");

  a_rsvd_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    bus_state == BUS_READ && (rd_idx == `PLCPR_IDX_CTRL || rd_idx == `PLCPR_IDX_FEATURE)
    |=> hrdata[31:6] == 26'h0)
    else $error("reserved bits read nonzero");

  a_unity_pass: assert property (@(posedge hclk) disable iff (!hresetn)
    (tx_valid && tx_ok && global_gain == 8'hff && preamble_gain == 8'hff
     && body_gain == 8'hff ##1 tx_ok) |=> tx_out == $past(tx_sample.data, 2))
    else $error("unity gains altered sample");

  a_global_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (tx_valid && tx_ok && global_gain == 8'h00 ##1 tx_ok) |=> tx_out == 16'h0000)
    else $error("zero global gain leaked");

  a_preamble_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (tx_valid && tx_ok && tx_sample.preamble && preamble_gain == 8'h00 ##1 tx_ok)
    |=> tx_out == 16'h0000)
    else $error("zero preamble gain leaked");

  a_body_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (tx_valid && tx_ok && !tx_sample.preamble && body_gain == 8'h00 ##1 tx_ok)
    |=> tx_out == 16'h0000)
    else $error("zero body gain leaked");

  a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    acc && !hwrite && bus_state == BUS_IDLE |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  a_write_no_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    acc && hwrite |=> hreadyout)
    else $error("write inserted a wait state");

  a_ctrl_rsvd_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    bus_state == BUS_READ && rd_idx == `PLCPR_IDX_CTRL |=> hrdata[31:5] == 27'h0)
    else $error("control reserved bits read nonzero");

  a_ctrl_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend && wr_idx == `PLCPR_IDX_CTRL |=> ctrl.phy_reset == $past(hwdata[`PLCPR_CTRL_PHY_RST]))
    else $error("PHY reset bit not written");

  a_reset_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl.phy_reset |=> !rx_enable && !tx_enable ##1 !tx_out_valid)
    else $error("activity while PHY held in reset");

  a_irq_cause: assert property (@(posedge hclk) disable iff (!hresetn)
    phy_irq |-> $past(wd_tick && phy_fault))
    else $error("interrupt without watchdog fault");

  a_wdog_off_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl.wdog_enable |=> !phy_irq)
    else $error("interrupt with watchdog disabled");

  a_gain_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend && wr_idx == `PLCPR_IDX_GLOBAL_GAIN |=> global_gain == $past(hwdata[7:0]))
    else $error("global gain not written");

  a_preamble_select: assert property (@(posedge hclk) disable iff (!hresetn)
    (tx_valid && tx_ok && tx_sample.preamble && preamble_gain == 8'hff && body_gain == 8'h00
     && global_gain == 8'hff ##1 tx_ok) |=> tx_out == $past(tx_sample.data, 2))
    else $error("preamble sample took body gain");

  a_body_select: assert property (@(posedge hclk) disable iff (!hresetn)
    (tx_valid && tx_ok && !tx_sample.preamble && body_gain == 8'hff && preamble_gain == 8'h00
     && global_gain == 8'hff ##1 tx_ok) |=> tx_out == $past(tx_sample.data, 2))
    else $error("body sample took preamble gain");

  a_tx_zero_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    !tx_out_valid |-> tx_out == 16'h0000)
    else $error("sample output nonzero while idle");

  c_wdog_error: cover property (@(posedge hclk) disable iff (!hresetn)
    wd_tick && phy_fault);

  c_reset_cycle: cover property (@(posedge hclk) disable iff (!hresetn)
    ctrl.phy_reset ##[1:20] !ctrl.phy_reset);

  c_preamble_to_body: cover property (@(posedge hclk) disable iff (!hresetn)
    tx_valid && tx_sample.preamble ##1 tx_valid && !tx_sample.preamble);

  c_sleep_entry: cover property (@(posedge hclk) disable iff (!hresetn)
    ctrl.phy_reset ##[1:20] ctrl.phy_reset && ctrl.physical_layer_sleep);

  c_gain_cascade: cover property (@(posedge hclk) disable iff (!hresetn)
    tx_out_valid && s1_gain != 8'hff);

endmodule

// ### plcpr_regs_bench.sv
// Self-checking bench for the PHY control register bank
`timescale 1ns/100ps
`include "plcpr_cfg.svh"

module plcpr_regs_bench;
  import plcpr_pkg::*;

  localparam logic [31:0] A_GG  = 32'({`PLCPR_IDX_GLOBAL_GAIN, 2'b00});
  localparam logic [31:0] A_CT  = 32'({`PLCPR_IDX_CTRL, 2'b00});
  localparam logic [31:0] A_FT  = 32'({`PLCPR_IDX_FEATURE, 2'b00});
  localparam logic [31:0] A_PG  = 32'({`PLCPR_IDX_PREAMBLE, 2'b00});
  localparam logic [31:0] A_BG  = 32'({`PLCPR_IDX_BODY, 2'b00});

  logic        hclk = 1'b0;
  logic        hresetn;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] hwdata = '0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        phy_fault = 1'b0;
  logic        phy_irq;
  plcpr_ctrl_s ctrl;
  plcpr_feat_s feat;
  logic        rx_enable;
  logic        tx_enable;
  logic        tx_valid = 1'b0;
  plcpr_smp_s  tx_sample = '0;
  logic        tx_out_valid;
  logic [15:0] tx_out;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          cyc = 0;

  always #4 hclk = ~hclk;

  plcpr_regs #(.WDOG_CYCLES(16)) i_plcpr_regs (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .phy_fault(phy_fault),
    .phy_irq(phy_irq), .ctrl(ctrl), .feat(feat), .rx_enable(rx_enable), .tx_enable(tx_enable),
    .tx_valid(tx_valid), .tx_sample(tx_sample), .tx_out_valid(tx_out_valid), .tx_out(tx_out)
  );

  task automatic final_report();
    $display("checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      $display("wrong value at %0t: run did not finish", $time);
      final_report();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wr ? d : 32'h0000_0000;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk(32'(hresp), 32'h0, "response");
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] tmp;
    bus(1'b1, a, d, tmp);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    chk(v, exp, "register read");
  endtask

  function automatic logic [15:0] sc(input logic [15:0] s, input logic [7:0] g);
    logic signed [24:0] p;
    p = $signed(s) * $signed({1'b0, g});
    return (g == 8'hff) ? s : p[23:8];
  endfunction

  task automatic send(input logic pre, input logic [15:0] d, input logic ok, input logic [15:0] exp);
    @(posedge hclk);
    tx_valid  <= 1'b1;
    tx_sample <= {pre, d};
    @(posedge hclk);
    tx_valid  <= 1'b0;
    @(posedge hclk);
    #1;
    chk(32'(tx_out_valid), 32'(ok), "sample strobe");
    chk(32'(tx_out), ok ? 32'(exp) : 32'h0, "sample value");
  endtask

  logic [31:0] adr [5] = '{A_GG, A_CT, A_FT, A_PG, A_BG};
  logic [31:0] rst [5] = '{32'h0000_00ff, 32'h0000_0004, 32'h0000_001f, 32'h0000_00ff, 32'h0000_00ff};
  logic [7:0]  gp [6] = '{8'hff, 8'h80, 8'hff, 8'h00, 8'hff, 8'hc0};
  logic [7:0]  gb [6] = '{8'hff, 8'hff, 8'h80, 8'hff, 8'h00, 8'ha0};
  logic [7:0]  gg [6] = '{8'hff, 8'hff, 8'h40, 8'hff, 8'hff, 8'h00};
  logic [15:0] smp [2] = '{16'h4000, 16'hb3c1};
  logic        seen;

  initial begin
    // Falling edge at time zero so the asynchronous reset takes effect
    hresetn <= 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 5; i++) rd_chk(adr[i], rst[i]);
    rd_chk(A_GG + 32'h4, 32'h0);
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      wr(A_FT, 32'h1 << i);
      rd_chk(A_FT, 32'h1 << i);
      chk(32'(feat), 32'h1 << i, "feature port");
    end
    wr(A_FT, 32'hffff_ffff);
    rd_chk(A_FT, 32'h3f);
    $display("test feature bits done");
    wr(A_CT, 32'hff);
    rd_chk(A_CT, 32'h1d);
    wr(A_CT, 32'h05);
    wr(A_CT, 32'h1d);
    chk(32'({rx_enable, tx_enable}), 32'h0, "sleep enables");
    send(1'b0, 16'h1234, 1'b0, 16'h0);
    wr(A_CT, 32'h05);
    chk(32'({rx_enable, tx_enable}), 32'h0, "reset enables");
    wr(A_CT, 32'h04);
    rd_chk(A_CT, 32'h04);
    chk(32'({rx_enable, tx_enable}), 32'h3, "awake enables");
    wr(A_CT, 32'h14);
    rd_chk(A_CT, 32'h14);
    chk(32'(ctrl), 32'h14, "control port");
    chk(32'({rx_enable, tx_enable}), 32'h1, "converter sleep");
    send(1'b0, 16'h1234, 1'b1, 16'h1234);
    wr(A_CT, 32'h04);
    $display("test power sequencing done");
    phy_fault <= 1'b1;
    seen = 1'b0;
    for (int n = 0; n < 40 && !seen; n++) begin
      @(posedge hclk);
      #1;
      seen = (phy_irq === 1'b1);
    end
    chk(32'(seen), 32'h1, "watchdog interrupt");
    @(posedge hclk);
    #1;
    chk(32'(phy_irq), 32'h0, "interrupt pulse");
    @(posedge hclk);
    phy_fault <= 1'b0;
    rd_chk(A_CT, 32'h06);
    wr(A_CT, 32'h04);
    rd_chk(A_CT, 32'h06);
    wr(A_CT, 32'h05);
    wr(A_CT, 32'h04);
    rd_chk(A_CT, 32'h04);
    wr(A_CT, 32'h00);
    phy_fault <= 1'b1;
    seen = 1'b0;
    for (int n = 0; n < 40; n++) begin
      @(posedge hclk);
      #1;
      if (phy_irq === 1'b1) seen = 1'b1;
    end
    chk(32'(seen), 32'h0, "disabled watchdog");
    @(posedge hclk);
    phy_fault <= 1'b0;
    rd_chk(A_CT, 32'h00);
    wr(A_CT, 32'h04);
    $display("test watchdog done");
    for (int c = 0; c < 6; c++) begin
      wr(A_PG, 32'(gp[c]));
      wr(A_BG, 32'(gb[c]));
      wr(A_GG, 32'(gg[c]));
      rd_chk(A_PG, 32'(gp[c]));
      rd_chk(A_BG, 32'(gb[c]));
      rd_chk(A_GG, 32'(gg[c]));
      for (int k = 0; k < 2; k++) begin
        send(1'b1, smp[k], 1'b1, sc(sc(smp[k], gp[c]), gg[c]));
        send(1'b0, smp[k], 1'b1, sc(sc(smp[k], gb[c]), gg[c]));
      end
    end
    $display("test transmit gains done");
    final_report();
  end
endmodule
